// ---- dv/jdp_dbg_model.sv ----
// Debugger model that drives the scan pins at the link clock rate
`timescale 1ns/1ps
`default_nettype none
module jdp_dbg_model (
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i
);
	// Test clock rests low between frames; other pins at pull-up level
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// Static pin levels, used across reset and in two-wire mode
	task automatic pins(input logic c, input logic d);
		tck_o = c;
		tdi_o = d;
	endtask
	// One 160 ns test clock cycle, well above twice the system period
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_o = tms;
		tdi_o = tdi;
		#80;
		tdo = tdo_i; // Late in the low phase, after the falling update
		tck_o = 1'b1;
		#80;
		tck_o = 1'b0;
		tdi_o = ~tdi; // Stale data turned round, not left showing
	endtask
	// Five high mode selects reach reset, then park in idle
	task automatic to_idle();
		logic t;
		#37; // Off the system clock's phase
		repeat (5) step(1'b1, 1'b0, t);
		step(1'b0, 1'b0, t);
	endtask
	// Idle to idle through one instruction or data shift of n bits
	task automatic scan(input logic ir, input int n, input logic [69:0] din,
		output logic [69:0] dout);
		logic t;
		int   i;
		dout = '0;
		step(1'b1, 1'b0, t);
		if (ir) step(1'b1, 1'b0, t);
		step(1'b0, 1'b0, t);
		step(1'b0, 1'b0, t);
		for (i = 0; i < n; i++) begin
			step(i == n - 1, din[i], dout[i]);
		end
		step(1'b1, 1'b0, t);
		step(1'b0, 1'b0, t);
	endtask
endmodule
`default_nettype wire

// ---- dv/jdp_debug_port_test.sv ----
// Self-checking bench for the debug port front end
`timescale 1ns/1ps
`default_nettype none
module jdp_debug_port_test;
	logic                   clk_i = 1'b0;
	logic                   resetn_i = 1'b0;
	logic                   cpu_valid_i = 1'b0;
	logic [23:0]            cpu_addr_i = 24'h00_0000;
	logic [7:0]             cpu_data_i = 8'h00;
	logic                   tw_out = 1'b0;
	logic                   tw_drv = 1'b0;
	logic                   tck, tms, dbg_tdi, pin_tdi, tdo, tdo_oe_n;
	logic                   tdi_out, tdi_oe_n, trig, trig_oe_n;
	logic                   dat_in, tw_clk, tw_en, ocd_en;
	jdp_pkg::jdp_bkpt_evt_s evt;
	jdp_pkg::jdp_bkpt_evt_s exp_q[$];
	int                     n_errors = 0;
	int                     checks_done = 0;
	int                     trig_len = 0;
	int                     exp_len = 2;

	always #5 clk_i = ~clk_i;
	// Data-in wire: device wins while it drives, else the debugger
	assign pin_tdi = !tdi_oe_n ? tdi_out : dbg_tdi;

	jdp_debug_port jdp_debug_port_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.tck_i(tck), .tms_i(tms), .tdi_i(pin_tdi), .tdi_o(tdi_out),
		.tdi_oe_n_o(tdi_oe_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
		.trig_o(trig), .trig_oe_n_o(trig_oe_n), .cpu_valid_i(cpu_valid_i),
		.cpu_addr_i(cpu_addr_i), .cpu_data_i(cpu_data_i),
		.two_wire_data_out_i(tw_out), .two_wire_data_drive_i(tw_drv),
		.two_wire_data_in_o(dat_in), .two_wire_clk_o(tw_clk),
		.two_wire_en_o(tw_en), .onchip_debug_unit_en_o(ocd_en), .evt_o(evt));
	jdp_dbg_model jdp_dbg_model_inst (.tck_o(tck), .tms_o(tms), .tdi_o(dbg_tdi),
		.tdo_i(tdo));

	////////////////////////////////////////////////////////////////////////
	task automatic check_val(input logic [69:0] got, input logic [69:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_evt(input jdp_pkg::jdp_bkpt_evt_s got,
		input jdp_pkg::jdp_bkpt_evt_s exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		if (n_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Reset for 16 cycles with the test clock parked at lvl
	task automatic do_reset(input logic lvl);
		jdp_dbg_model_inst.pins(lvl, 1'b1);
		cyc(1);
		resetn_i = 1'b0;
		cyc(16);
		resetn_i = 1'b1;
		cyc(2);
	endtask
	// A processor access held for n cycles, then idle long enough for the pulse to end
	task automatic bus(input logic [23:0] a, input logic [7:0] d, input int n);
		cpu_addr_i = a;
		cpu_data_i = d;
		cpu_valid_i = 1'b1;
		cyc(n);
		cpu_valid_i = 1'b0;
		cyc(5);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Event watcher: pops the oldest note per pulse, measures trigger length
	always @(negedge clk_i) begin
		if (resetn_i) begin
			if (evt !== '0) begin
				if (exp_q.size() == 0) check_evt(evt, '0);
				else check_evt(evt, exp_q.pop_front());
				check_val(trig_oe_n, 1'b0);
			end
			if (trig === 1'b1) trig_len++;
			else begin
				if (trig_len != 0) check_val(trig_len, exp_len);
				check_val(trig_oe_n, 1'b1);
				trig_len = 0;
			end
		end
	end
	// Serial out must never move while the test clock is high
	always @(tdo) begin
		if (resetn_i === 1'b1 && tck === 1'b1) check_val(tck, 1'b0);
	end
	// Hang guard
	initial begin
		#500us;
		n_errors++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		jdp_pkg::jdp_bkpt_cfg_s cfg;
		logic [69:0] got;
		logic [69:0] p;
		logic [23:0] a;
		logic [7:0]  d;
		logic [23:0] edge_a [4];
		logic [3:0]  codes [3];
		logic        c;
		int          i;
		void'($urandom(32'h14d7_16fe));
		edge_a = '{24'h00_0FFF, 24'h00_1000, 24'h00_10FF, 24'h00_1100};
		codes = '{jdp_pkg::IR_EXTEST, jdp_pkg::IR_SAMPLE, jdp_pkg::IR_BYPASS};
		cfg = jdp_pkg::CFG_RESET;
		cfg.addr_lo = 24'h00_1000;
		cfg.addr_hi = 24'h00_10FF;
		cfg.data_val = 8'hA0;
		cfg.data_mask = 8'hF0;
		{cfg.range_en, cfg.data_en, cfg.trig_en, cfg.trace_start} = 4'hF;
		cfg.break_en = 1'b1;
		// Low test clock at reset end picks the debug unit
		tw_drv = 1'b1;
		do_reset(1'b0);
		check_val(ocd_en, 1'b1);
		check_val(tw_en, 1'b0);
		check_val(tw_clk, 1'b1);
		check_val(tdi_oe_n, 1'b1);
		tw_drv = 1'b0;
		// Instruction capture value, then setup readback through the scan path
		jdp_dbg_model_inst.to_idle();
		jdp_dbg_model_inst.scan(1'b1, 4, 70'(jdp_pkg::IR_BKPT), got);
		check_val(got[3:0], jdp_pkg::IR_CAPTURE);
		jdp_dbg_model_inst.scan(1'b0, 70, cfg, got);
		check_val(got, jdp_pkg::CFG_RESET);
		jdp_dbg_model_inst.scan(1'b0, 70, cfg, got);
		check_val(got, cfg);
		// Five high selects reset the port, which falls back to bypass
		jdp_dbg_model_inst.to_idle();
		check_val(tdo_oe_n, 1'b1);
		p = 70'($urandom);
		jdp_dbg_model_inst.scan(1'b0, 8, p, got);
		check_val(got[7:0], {p[6:0], 1'b0});
		// Boundary scan and other codes fall to the one-bit bypass
		for (i = 0; i < 3; i++) begin
			p = 70'($urandom);
			jdp_dbg_model_inst.scan(1'b1, 4, 70'(codes[i]), got);
			jdp_dbg_model_inst.scan(1'b0, 8, p, got);
			check_val(got[7:0], {p[6:0], 1'b0});
		end
		cyc(20);
		// Range edges first, then random addresses around the range
		for (i = 0; i < 24; i++) begin
			a = (i < 4) ? edge_a[i] : 24'h00_0FF0 + 24'($urandom_range(0, 287));
			d = {(i < 4 || $urandom_range(0, 1)) ? 4'hA : 4'($urandom), 4'($urandom)};
			if (a >= cfg.addr_lo && a <= cfg.addr_hi && d[7:4] == 4'hA) exp_q.push_back(3'b110);
			bus(a, d, 1);
		end
		// Back to back hits restart the pulse
		exp_len = 3;
		exp_q.push_back(3'b110);
		exp_q.push_back(3'b110);
		bus(cfg.addr_lo, 8'hA5, 2);
		exp_len = 2;
		check_val(exp_q.size(), 0);
		// High test clock at reset end picks the two-wire port
		do_reset(1'b1);
		check_val(tw_en, 1'b1);
		check_val(ocd_en, 1'b0);
		for (i = 0; i < 8; i++) begin
			tw_out = 1'($urandom);
			tw_drv = 1'($urandom);
			c = 1'($urandom);
			p[0] = 1'($urandom);
			jdp_dbg_model_inst.pins(c, p[0]);
			cyc(4);
			check_val(tdi_oe_n, !tw_drv);
			if (tw_drv) check_val(tdi_out, tw_out);
			check_val(tw_clk, c);
			check_val(dat_in, tw_drv ? tw_out : p[0]);
		end
		// An access matching the bench setup raises nothing: the debug unit is off and reset cleared its setup
		bus(cfg.addr_lo, 8'hA5, 1);
		give_verdict();
	end
endmodule
`default_nettype wire

// ---- hdl/jdp_debug_port.sv ----
// Debug port front end: mode pick at reset, scan port, breakpoint and trigger pin
//
// How it works
// - Test clock high at reset end powers down the unit, enables two-wire mode.
// - Data-in pin is input only when enabled, two-wire data line otherwise.
// - Mode select is sampled on rising test clock edges while enabled.
// - Serial data in is captured on rising test clock edges while enabled.
// - Serial data out changes only on falling test clock edges.
// - Trigger pin pulses high on a trigger event, floats otherwise.
// - Standard port control; no boundary register, scan codes act as bypass.
// - Two addresses form a range, masked data match, trace start/stop, trigger.
`timescale 1ns/1ps
`default_nettype none
module jdp_debug_port (
	input  wire logic                   clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   tck_i,
	input  wire logic                   tms_i,
	input  wire logic                   tdi_i,
	output logic                        tdi_o,
	output logic                        tdi_oe_n_o,
	output logic                        tdo_o,
	output logic                        tdo_oe_n_o,
	output logic                        trig_o,
	output logic                        trig_oe_n_o,
	input  wire logic                   cpu_valid_i,
	input  wire logic [23:0]            cpu_addr_i,
	input  wire logic [7:0]             cpu_data_i,
	input  wire logic                   two_wire_data_out_i,
	input  wire logic                   two_wire_data_drive_i,
	output logic                        two_wire_data_in_o,
	output logic                        two_wire_clk_o,
	output logic                        two_wire_en_o,
	output logic                        onchip_debug_unit_en_o,
	output var  jdp_pkg::jdp_bkpt_evt_s evt_o
);

	////////////////////////////////////////////////////////////////////////
	// System clock side: pin synchronisers and mode pick

	logic tck_s1;
	logic tck_s2;
	logic tdi_s1;
	logic tdi_s2;
	logic mode_done;
	logic ocd_en;
	logic two_wire_en;

	// Test clock level flops carry no reset: they must keep sampling the
	// pin while reset is held, or the pick would only see a reset value
	always_ff @(posedge clk_i) begin
		tck_s1 <= tck_i;
		tck_s2 <= tck_s1;
	end

	// Data pin flops, reset to the pull-up level
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tdi_s1 <= 1'b1;
			tdi_s2 <= 1'b1;
		end else begin
			tdi_s1 <= tdi_i;
			tdi_s2 <= tdi_s1;
		end
	end

	// Pick once, on the first edge after release; a low held two cycles
	// before release has by then reached the second flop
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_done   <= 1'b0;
			ocd_en      <= 1'b0;
			two_wire_en <= 1'b0;
		end else if (!mode_done) begin
			mode_done   <= 1'b1;
			ocd_en      <= !tck_s2;
			two_wire_en <= tck_s2;
		end
	end

	assign onchip_debug_unit_en_o = ocd_en;
	assign two_wire_en_o          = two_wire_en;

	// Two-wire pin sharing; the data pin only drives in two-wire mode
	logic next_tdi_oe_n;

	assign next_tdi_oe_n = !(two_wire_en && two_wire_data_drive_i);

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tdi_o              <= 1'b1;
			tdi_oe_n_o         <= 1'b1;
			two_wire_data_in_o <= 1'b1;
			two_wire_clk_o     <= 1'b1;
		end else begin
			tdi_o              <= two_wire_data_out_i;
			tdi_oe_n_o         <= next_tdi_oe_n;
			two_wire_data_in_o <= tdi_s2;
			two_wire_clk_o     <= tck_s2 | !two_wire_en;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Test clock side: enable crossing, instruction and data registers

	logic                    en_t1;
	logic                    en_t2;
	jdp_pkg::jdp_tap_ctl_s   ctl;
	logic [jdp_pkg::IR_W-1:0]  ir_sh;
	logic [jdp_pkg::IR_W-1:0]  ir;
	logic [jdp_pkg::CFG_W-1:0] dr_sh;
	logic                    byp;
	jdp_pkg::jdp_bkpt_cfg_s  cfg_hold;
	logic                    upd_tgl;
	logic                    bkpt_sel;
	logic                    shifting;
	logic                    shift_out;

	// Enable level into the test clock domain
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			en_t1 <= 1'b0;
			en_t2 <= 1'b0;
		end else begin
			en_t1 <= ocd_en;
			en_t2 <= en_t1;
		end
	end

	jdp_tap u_tap (
		.tck_i    (tck_i),
		.resetn_i (resetn_i),
		.en_i     (en_t2),
		.tms_i    (tms_i),
		.ctl_o    (ctl)
	);

	// Only the breakpoint code owns a data register; boundary scan codes
	// have no register behind them and select the one-bit bypass
	assign bkpt_sel  = ir == jdp_pkg::IR_BKPT;
	assign shifting  = ctl.shift_dr || ctl.shift_ir;
	assign shift_out = ctl.shift_ir ? ir_sh[0] : (bkpt_sel ? dr_sh[0] : byp);

	// Instruction register
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ir_sh <= jdp_pkg::IR_CAPTURE;
			ir    <= jdp_pkg::IR_BYPASS;
		end else if (ctl.tlr) begin
			ir <= jdp_pkg::IR_BYPASS;
		end else if (ctl.cap_ir) begin
			ir_sh <= jdp_pkg::IR_CAPTURE;
		end else if (ctl.shift_ir) begin
			ir_sh <= {tdi_i, ir_sh[jdp_pkg::IR_W-1:1]};
		end else if (ctl.upd_ir) begin
			ir <= ir_sh;
		end
	end

	// Data registers; capture reads back the held setup
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dr_sh <= '0;
			byp   <= 1'b0;
		end else if (ctl.cap_dr) begin
			dr_sh <= cfg_hold;
			byp   <= 1'b0;
		end else if (ctl.shift_dr && bkpt_sel) begin
			dr_sh <= {tdi_i, dr_sh[jdp_pkg::CFG_W-1:1]};
		end else if (ctl.shift_dr) begin
			byp <= tdi_i;
		end
	end

	// Held setup and its toggle; the hold stays still until the next
	// update, far longer than the system side needs to copy it
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_hold <= jdp_pkg::CFG_RESET;
			upd_tgl  <= 1'b0;
		end else if (ctl.upd_dr && bkpt_sel) begin
			cfg_hold <= dr_sh;
			upd_tgl  <= !upd_tgl;
		end
	end

	// Serial out launched on the falling edge, floats when not shifting
	always_ff @(negedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tdo_o      <= 1'b1;
			tdo_oe_n_o <= 1'b1;
		end else begin
			tdo_o      <= shifting ? shift_out : tdo_o;
			tdo_oe_n_o <= !shifting;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// System clock side: setup copy and breakpoint match

	logic                   tgl_s1;
	logic                   tgl_s2;
	logic                   tgl_s3;
	logic                   new_cfg;
	jdp_pkg::jdp_bkpt_cfg_s cfg;

	// Toggle handshake brings each update across
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
		end else begin
			tgl_s1 <= upd_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
		end
	end

	assign new_cfg = tgl_s2 ^ tgl_s3;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg <= jdp_pkg::CFG_RESET;
		end else if (new_cfg) begin
			cfg <= cfg_hold;
		end
	end

	// Range or single-address match, data match under the mask
	logic addr_lo_hit;
	logic addr_hi_hit;
	logic in_range;
	logic addr_hit;
	logic data_ok;
	logic hit;
	logic trig_hit;

	assign addr_lo_hit = cpu_addr_i == cfg.addr_lo;
	assign addr_hi_hit = cpu_addr_i == cfg.addr_hi;
	assign in_range    = (cpu_addr_i >= cfg.addr_lo) && (cpu_addr_i <= cfg.addr_hi);
	assign addr_hit    = cfg.range_en ? in_range : (addr_lo_hit || addr_hi_hit);
	assign data_ok     = !cfg.data_en ||
		(((cpu_data_i ^ cfg.data_val) & cfg.data_mask) == '0);
	assign hit         = ocd_en && cpu_valid_i && addr_hit && data_ok;
	assign trig_hit    = hit && cfg.trig_en;

	// Actions registered so they leave as clean one-cycle pulses
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			evt_o <= '0;
		end else begin
			evt_o.brk         <= hit && cfg.break_en;
			evt_o.trace_start <= hit && cfg.trace_start;
			evt_o.trace_stop  <= hit && cfg.trace_stop;
		end
	end

	// Trigger pulse; a new hit restarts it, so the pulse runs on for the
	// pulse length after the last hit
	logic [1:0] trig_cnt;
	logic [1:0] next_trig_cnt;

	assign next_trig_cnt = trig_hit ? jdp_pkg::TRIG_PULSE_CNT :
		(trig_cnt != jdp_pkg::TRIG_CNT_ZERO) ? trig_cnt - jdp_pkg::TRIG_CNT_STEP :
		jdp_pkg::TRIG_CNT_ZERO;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			trig_cnt    <= jdp_pkg::TRIG_CNT_ZERO;
			trig_o      <= 1'b0;
			trig_oe_n_o <= 1'b1;
		end else begin
			trig_cnt    <= next_trig_cnt;
			trig_o      <= next_trig_cnt != jdp_pkg::TRIG_CNT_ZERO;
			trig_oe_n_o <= next_trig_cnt == jdp_pkg::TRIG_CNT_ZERO;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	chk_mode_pick_sync: assert property (@(posedge clk_i) disable iff (!resetn_i)
		$rose(mode_done) |-> ocd_en == !$past(tck_s2))
		else $error("mode not taken from synchronised test clock");

	chk_mode_exclusive: assert property (@(posedge clk_i) disable iff (!resetn_i)
		mode_done |=> $stable(ocd_en) && (ocd_en != two_wire_en))
		else $error("debug unit and two-wire mode not exclusive");

	chk_pin_input_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!two_wire_en |-> tdi_oe_n_o)
		else $error("data-in pin driven outside two-wire mode");

	chk_two_wire_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
		two_wire_en && two_wire_data_drive_i |=> !tdi_oe_n_o)
		else $error("two-wire data line not driven");

	chk_tdi_capture: assert property (@(posedge tck_i) disable iff (!resetn_i)
		ctl.shift_dr && bkpt_sel |=> dr_sh[jdp_pkg::CFG_W-1] == $past(tdi_i))
		else $error("serial data not captured on rising edge");

	chk_bypass_bit: assert property (@(posedge tck_i) disable iff (!resetn_i)
		ctl.shift_dr && !bkpt_sel |=> byp == $past(tdi_i))
		else $error("bypass bit did not follow serial input");

	chk_tdo_falling: assert property (@(negedge tck_i) disable iff (!resetn_i)
		shifting |=> tdo_o == $past(shift_out) && !tdo_oe_n_o)
		else $error("serial out not launched on falling edge");

	chk_trig_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
		trig_hit |=> (trig_o && !trig_oe_n_o) [*2])
		else $error("trigger pulse too short");

	chk_trig_float: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!trig_o |-> trig_oe_n_o)
		else $error("trigger pin driven while idle");

	chk_range_break: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ocd_en && cpu_valid_i && cfg.range_en && !cfg.data_en && cfg.break_en &&
		cpu_addr_i >= cfg.addr_lo && cpu_addr_i <= cfg.addr_hi |=> evt_o.brk)
		else $error("address in range did not break");

	chk_data_mask: assert property (@(posedge clk_i) disable iff (!resetn_i)
		cfg.data_en && (((cpu_data_i ^ cfg.data_val) & cfg.data_mask) != '0)
		|=> evt_o == '0 && !$rose(trig_o))
		else $error("masked data mismatch still matched");

endmodule
`default_nettype wire

// ---- hdl/jdp_pkg.sv ----
// Shared constants and types for the debug port activation front end
package jdp_pkg;

	// Widths of the watched processor bus and of the instruction register
	localparam int ADDR_W = 24;
	localparam int DATA_W = 8;
	localparam int IR_W   = 4;

	// Instruction codes; both boundary scan codes fall through to bypass
	localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
	localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h1;
	localparam logic [IR_W-1:0] IR_BKPT    = 4'h2;
	localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

	// Trigger pulse length in system clock cycles
	localparam logic [1:0] TRIG_PULSE_CNT = 2'h2;
	localparam logic [1:0] TRIG_CNT_ZERO  = 2'h0;
	localparam logic [1:0] TRIG_CNT_STEP  = 2'h1;

	// Test access port states, one-hot
	typedef enum logic [15:0] {
		TAP_RESET    = 16'h0001,
		TAP_IDLE     = 16'h0002,
		TAP_SEL_DR   = 16'h0004,
		TAP_CAP_DR   = 16'h0008,
		TAP_SHIFT_DR = 16'h0010,
		TAP_EXIT1_DR = 16'h0020,
		TAP_PAUSE_DR = 16'h0040,
		TAP_EXIT2_DR = 16'h0080,
		TAP_UPD_DR   = 16'h0100,
		TAP_SEL_IR   = 16'h0200,
		TAP_CAP_IR   = 16'h0400,
		TAP_SHIFT_IR = 16'h0800,
		TAP_EXIT1_IR = 16'h1000,
		TAP_PAUSE_IR = 16'h2000,
		TAP_EXIT2_IR = 16'h4000,
		TAP_UPD_IR   = 16'h8000
	} jdp_tap_e;

	// Strobes decoded from the port state
	typedef struct packed {
		logic tlr;
		logic cap_dr;
		logic shift_dr;
		logic upd_dr;
		logic cap_ir;
		logic shift_ir;
		logic upd_ir;
	} jdp_tap_ctl_s;

	// Breakpoint setup loaded through the scan chain
	typedef struct packed {
		logic [ADDR_W-1:0] addr_lo;
		logic [ADDR_W-1:0] addr_hi;
		logic [DATA_W-1:0] data_val;
		logic [DATA_W-1:0] data_mask;
		logic              range_en;
		logic              data_en;
		logic              trig_en;
		logic              trace_start;
		logic              trace_stop;
		logic              break_en;
	} jdp_bkpt_cfg_s;

	localparam int            CFG_W     = $bits(jdp_bkpt_cfg_s);
	localparam jdp_bkpt_cfg_s CFG_RESET = '0;

	// Breakpoint actions, one-cycle pulses
	typedef struct packed {
		logic brk;
		logic trace_start;
		logic trace_stop;
	} jdp_bkpt_evt_s;

endpackage

// ---- hdl/jdp_tap.sv ----
// Test access port state machine on the test clock
`timescale 1ns/1ps
`default_nettype none
module jdp_tap (
	input  wire logic                 tck_i,
	input  wire logic                 resetn_i,
	input  wire logic                 en_i,
	input  wire logic                 tms_i,
	output var  jdp_pkg::jdp_tap_ctl_s ctl_o
);

	jdp_pkg::jdp_tap_e state;
	jdp_pkg::jdp_tap_e step;
	jdp_pkg::jdp_tap_e next_state;

	// Standard walk steered by the select level at each rising edge
	always_comb begin
		case (state)
			jdp_pkg::TAP_RESET:    step = tms_i ? jdp_pkg::TAP_RESET    : jdp_pkg::TAP_IDLE;
			jdp_pkg::TAP_IDLE:     step = tms_i ? jdp_pkg::TAP_SEL_DR   : jdp_pkg::TAP_IDLE;
			jdp_pkg::TAP_SEL_DR:   step = tms_i ? jdp_pkg::TAP_SEL_IR   : jdp_pkg::TAP_CAP_DR;
			jdp_pkg::TAP_CAP_DR:   step = tms_i ? jdp_pkg::TAP_EXIT1_DR : jdp_pkg::TAP_SHIFT_DR;
			jdp_pkg::TAP_SHIFT_DR: step = tms_i ? jdp_pkg::TAP_EXIT1_DR : jdp_pkg::TAP_SHIFT_DR;
			jdp_pkg::TAP_EXIT1_DR: step = tms_i ? jdp_pkg::TAP_UPD_DR   : jdp_pkg::TAP_PAUSE_DR;
			jdp_pkg::TAP_PAUSE_DR: step = tms_i ? jdp_pkg::TAP_EXIT2_DR : jdp_pkg::TAP_PAUSE_DR;
			jdp_pkg::TAP_EXIT2_DR: step = tms_i ? jdp_pkg::TAP_UPD_DR   : jdp_pkg::TAP_SHIFT_DR;
			jdp_pkg::TAP_UPD_DR:   step = tms_i ? jdp_pkg::TAP_SEL_DR   : jdp_pkg::TAP_IDLE;
			jdp_pkg::TAP_SEL_IR:   step = tms_i ? jdp_pkg::TAP_RESET    : jdp_pkg::TAP_CAP_IR;
			jdp_pkg::TAP_CAP_IR:   step = tms_i ? jdp_pkg::TAP_EXIT1_IR : jdp_pkg::TAP_SHIFT_IR;
			jdp_pkg::TAP_SHIFT_IR: step = tms_i ? jdp_pkg::TAP_EXIT1_IR : jdp_pkg::TAP_SHIFT_IR;
			jdp_pkg::TAP_EXIT1_IR: step = tms_i ? jdp_pkg::TAP_UPD_IR   : jdp_pkg::TAP_PAUSE_IR;
			jdp_pkg::TAP_PAUSE_IR: step = tms_i ? jdp_pkg::TAP_EXIT2_IR : jdp_pkg::TAP_PAUSE_IR;
			jdp_pkg::TAP_EXIT2_IR: step = tms_i ? jdp_pkg::TAP_UPD_IR   : jdp_pkg::TAP_SHIFT_IR;
			jdp_pkg::TAP_UPD_IR:   step = tms_i ? jdp_pkg::TAP_SEL_DR   : jdp_pkg::TAP_IDLE;
			default:               step = jdp_pkg::TAP_RESET;
		endcase
	end

	// A powered-down unit parks in reset
	assign next_state = en_i ? step : jdp_pkg::TAP_RESET;

	// Select sampled on the rising test clock edge
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= jdp_pkg::TAP_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Strobes straight from the one-hot state
	assign ctl_o.tlr      = state == jdp_pkg::TAP_RESET;
	assign ctl_o.cap_dr   = state == jdp_pkg::TAP_CAP_DR;
	assign ctl_o.shift_dr = state == jdp_pkg::TAP_SHIFT_DR;
	assign ctl_o.upd_dr   = state == jdp_pkg::TAP_UPD_DR;
	assign ctl_o.cap_ir   = state == jdp_pkg::TAP_CAP_IR;
	assign ctl_o.shift_ir = state == jdp_pkg::TAP_SHIFT_IR;
	assign ctl_o.upd_ir   = state == jdp_pkg::TAP_UPD_IR;

	////////////////////////////////////////////////////////////////////////
	// Checks

	chk_tms_reset: assert property (@(posedge tck_i) disable iff (!resetn_i)
		(en_i && tms_i) [*5] |=> state == jdp_pkg::TAP_RESET)
		else $error("five select highs did not reach reset");

	chk_tms_idle: assert property (@(posedge tck_i) disable iff (!resetn_i)
		en_i && state == jdp_pkg::TAP_UPD_DR && !tms_i |=> state == jdp_pkg::TAP_IDLE)
		else $error("update with select low did not go idle");

endmodule
`default_nettype wire
